//--- common/imn_defines.vh
`ifndef IMN_DEFINES_VH
`define IMN_DEFINES_VH
`define IMN_NSRC          6
`define IMN_SRC_EVTQ      0
`define IMN_SRC_S_EVTQ    1
`define IMN_SRC_PRIQ      2
`define IMN_SRC_SYNC      3
`define IMN_SRC_S_SYNC    4
`define IMN_SRC_GERR      5
`define IMN_SECURE_MASK   6'h1_2
// per-source register block: 4 words from this base, stride 0x20
`define IMN_SRC_BASE      12'h1_00
`define IMN_SRC_STRIDE_LG 5
`define IMN_SRC_PAGE      4'h1
`define IMN_ADDR_LO_MASK  32'hFFFF_FFFC
`define IMN_OFF_ADDR_LO   3'h0
`define IMN_OFF_ADDR_HI   3'h1
`define IMN_OFF_DATA      3'h2
`define IMN_OFF_ATTR      3'h3
`define IMN_REG_IDR       12'h0_00
`define IMN_REG_ENABLE    12'h0_04
`define IMN_REG_STATUS    12'h0_08
`define IMN_REG_REQTAG    12'h0_0C
// attr: [3:0] memory type, [5:4] shareability
`define IMN_MT_DEVICE     4'h0
`define IMN_MT_NC         4'h4
`define IMN_SH_OUTER      2'h2
`define IMN_RESP_OKAY     2'h0
`define IMN_RESP_SLVERR   2'h2
`endif

//--- test/imn_notifier_properties.sv
module imn_props #(
	parameter        SID_W   = 16,
	parameter [15:0] REQ_TAG = 16'hF_FFF
) (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             info_visible,
	input wire logic [SID_W-1:0] client_stream_tag_in,
	input wire logic [SID_W-1:0] client_stream_tag_out,
	input wire logic [5:0]       irq_pulse,
	input wire logic [63:0]      m_awaddr,
	input wire logic             m_awvalid,
	input wire logic             m_awready,
	input wire logic [31:0]      m_wdata,
	input wire logic             m_wvalid,
	input wire logic             m_wready,
	input wire logic [3:0]       m_memtype,
	input wire logic [1:0]       m_share,
	input wire logic [15:0]      m_requester_tag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dcb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_aw_wait; m_awvalid && !m_awready; endsequence
	sequence s_w_wait; m_wvalid && !m_wready; endsequence
	property p_aw_hold; s_aw_wait |=> m_awvalid && $stable(m_awaddr); endproperty
	a_aw_hold: assert property (p_aw_hold) else $error("write address not held");
	property p_w_hold; s_w_wait |=> m_wvalid && $stable(m_wdata); endproperty
	a_w_hold: assert property (p_w_hold) else $error("write data not held");
	property p_share; m_awvalid && m_memtype <= 4'h4 |-> m_share == 2'h2; endproperty
	a_share: assert property (p_share) else $error("shareability not forced");
	property p_tag; m_awvalid |-> m_requester_tag == REQ_TAG; endproperty
	a_tag: assert property (p_tag) else $error("requester tag wrong");
	property p_sid; client_stream_tag_out == client_stream_tag_in; endproperty
	a_sid: assert property (p_sid) else $error("stream tag not passed");
	property p_gate; |irq_pulse |-> $past(info_visible); endproperty
	a_gate: assert property (p_gate) else $error("pulse before info visible");
	property p_addr; m_awvalid |-> m_awaddr != 64'h0 && m_awaddr[1:0] == 2'h0; endproperty
	a_addr: assert property (p_addr) else $error("bad message address");
	property p_edge; irq_pulse[0] |=> !irq_pulse[0]; endproperty
	a_edge: assert property (p_edge) else $error("wired output not a pulse");
endmodule // imn_props

bind imn_notifier imn_props #(.SID_W(SID_W), .REQ_TAG(REQ_TAG)) i_imn_props (.*);

//--- test/imn_sink.sv
module imn_sink (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic slow,
	input  wire logic m_awvalid,
	output wire logic m_awready,
	input  wire logic m_wvalid,
	output wire logic m_wready,
	output logic      m_bvalid,
	input  wire logic m_bready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_q;
	logic       aw_q;
	logic       w_q;
	// slow mode stalls both channels so hold-until-taken gets exercised
	assign m_awready = !aw_q && (!slow || wait_q == 2'd3);
	assign m_wready  = !w_q && (!slow || wait_q == 2'd3);
	always @(posedge aclk) begin
		if (!aresetn || m_bvalid && m_bready) begin
			wait_q <= 2'd0;
			aw_q <= 1'b0;
			w_q <= 1'b0;
			m_bvalid <= 1'b0;
		end else begin
			if (m_awvalid && wait_q != 2'd3)
				wait_q <= wait_q + 2'd1;
			aw_q <= aw_q | m_awvalid & m_awready;
			w_q <= w_q | m_wvalid & m_wready;
			m_bvalid <= (aw_q | m_awvalid & m_awready) & (w_q | m_wvalid & m_wready);
		end
	end
endmodule // imn_sink

//--- test/tb_top.sv
`include "imn_defines.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [15:0] TAG = 16'hA_5C3; // arbitrary value
	logic        aclk = 0, aresetn = 0, slow = 0, info_visible = 1;
	logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
	logic [11:0] s_awaddr = 0, s_araddr = 0;
	logic [31:0] s_wdata = 0, s_rdata, m_wdata, cap_data;
	logic [3:0]  s_wstrb = 4'hF, m_memtype;
	logic [1:0]  s_bresp, s_rresp, m_share;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, m_awvalid, m_wvalid;
	logic        m_bready, m_awready, m_wready, m_bvalid, m_nonsecure_attribute;
	logic [15:0] client_stream_tag_in = 16'h1_234, client_stream_tag_out, m_requester_tag;
	logic [5:0]  irq_pulse, trg = 0, seen = 0;
	logic        clr_seen = 0;
	logic [63:0] m_awaddr, cap_addr;
	logic [6:0]  cap_attr;
	int          errors = 0, num_checks = 0, wr_cnt = 0, cyc = 0;
	wire evtq_nonempty = trg[0], s_evtq_nonempty = trg[1], priq_irq_cond = trg[2];
	wire sync_done = trg[3], s_sync_done = trg[4], gerr_set = trg[5];

	imn_notifier #(.REQ_TAG(TAG)) i_imn_notifier (.*);
	imn_sink i_imn_sink (.*);

	always #4 aclk = ~aclk;
	always @(posedge aclk) begin
		seen <= clr_seen ? 6'h00 : seen | irq_pulse;
		if (m_awvalid && m_awready) begin
			cap_addr <= m_awaddr;
			cap_attr <= {m_nonsecure_attribute, m_share, m_memtype};
		end
		if (m_wvalid && m_wready)
			cap_data <= m_wdata;
		// counted on the response so both captures have landed
		if (m_bvalid && m_bready)
			wr_cnt <= wr_cnt + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			stop_test();
		end
	end

	task automatic stop_test;
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 0;
		w = 0;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1;
		s_wvalid <= 1;
		s_bready <= 1;
		do begin
			@(posedge aclk);
			aw |= s_awvalid & s_awready;
			w |= s_wvalid & s_wready;
			s_awvalid <= !aw;
			s_wvalid <= !w;
		end while (!(aw && w));
		do @(posedge aclk); while (!s_bvalid);
		s_bready <= 0;
		chk(s_bresp, `IMN_RESP_OKAY);
	endtask

	task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1;
		s_rready <= 1;
		do @(posedge aclk); while (!s_arready);
		s_arvalid <= 0;
		do @(posedge aclk); while (!s_rvalid);
		s_rready <= 0;
		chk(s_rdata, d);
		chk(s_rresp, r);
	endtask

	task automatic src(input logic [11:0] b, input logic [31:0] a, d, input logic [5:0] at);
		axi_wr(b, a);
		axi_wr(b + 12'h4, 32'h0);
		axi_wr(b + 12'h8, d);
		axi_wr(b + 12'hC, {26'h0, at});
	endtask

	task automatic trig(input logic [5:0] m);
		@(posedge aclk);
		clr_seen <= 1;
		@(posedge aclk);
		clr_seen <= 0;
		trg <= m;
		@(posedge aclk);
		trg <= 6'h0;
	endtask

	task automatic t_sync;
		src(12'h160, 32'h1234_5670, 32'hCAFE_0003, 6'h00);
		axi_wr(`IMN_REG_ENABLE, 32'h0000_0018);
		@(posedge aclk);
		info_visible <= 0;
		trig(6'h08);
		repeat (8) @(posedge aclk);
		chk(seen, 6'h00);
		chk(wr_cnt, 0);
		info_visible <= 1;
		wait (wr_cnt == 1);
		chk(seen, 6'h08);
		chk(cap_addr, 64'h1234_5670);
		chk(cap_data, 32'hCAFE_0003);
		chk(cap_attr, {1'b1, 2'h2, 4'h0});
	endtask

	task automatic t_secure;
		src(12'h180, 32'h0, 32'h5EC0_0004, 6'h18);
		axi_wr(`IMN_REG_ENABLE, 32'h0000_0010);
		trig(6'h10);
		repeat (10) @(posedge aclk);
		chk(seen, 6'h10);
		chk(wr_cnt, 1);
		axi_wr(12'h180, 32'h0000_4440);
		trig(6'h10);
		wait (wr_cnt == 2);
		chk(cap_attr, {1'b0, 2'h1, 4'h8});
		chk(cap_data, 32'h5EC0_0004);
	endtask

	task automatic t_enable;
		axi_wr(`IMN_REG_ENABLE, 32'h0);
		trig(6'h20);
		axi_wr(`IMN_REG_ENABLE, 32'h0000_0020);
		repeat (6) @(posedge aclk);
		chk(seen, 6'h00);
		trig(6'h20);
		repeat (10) @(posedge aclk);
		chk(seen, 6'h20);
		chk(wr_cnt, 2);
	endtask

	task automatic t_stall;
		@(posedge aclk);
		slow <= 1;
		src(12'h100, 32'h0000_2000, 32'hE0E0_0000, 6'h04);
		src(12'h140, 32'h0000_3000, 32'hD2D2_0002, 6'h3F);
		axi_wr(`IMN_REG_ENABLE, 32'h0000_0005);
		trig(6'h05);
		wait (wr_cnt == 3);
		chk(cap_data, 32'hE0E0_0000);
		chk(cap_addr, 64'h0000_2000);
		chk(cap_attr, {1'b1, 2'h2, 4'h4});
		wait (wr_cnt == 4);
		chk(seen, 6'h05);
		chk(cap_data, 32'hD2D2_0002);
		chk(cap_attr, {1'b1, 2'h3, 4'hF});
		@(posedge aclk);
		slow <= 0;
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		axi_rd(`IMN_REG_IDR, 32'h0000_000F, `IMN_RESP_OKAY);
		axi_rd(`IMN_REG_REQTAG, {16'h0, TAG}, `IMN_RESP_OKAY);
		axi_rd(`IMN_REG_ENABLE, 32'h0, `IMN_RESP_OKAY);
		axi_rd(12'hFF0, 32'h0, `IMN_RESP_SLVERR);
		chk(client_stream_tag_out, client_stream_tag_in);
		t_sync();
		t_secure();
		t_enable();
		t_stall();
		stop_test();
	end
endmodule // tb_top

//--- verilog/imn_notifier.v
// The AXI4-Lite slave port and the register addresses were decided locally.
`include "imn_defines.vh"

module imn_notifier #(
	parameter MSI_NS_SUPPORT = 1,
	parameter MSI_S_SUPPORT  = 1,
	parameter WIRED_SUPPORT  = 1,
	parameter COHACC         = 1,
	parameter SID_W          = 16,
	parameter [15:0] REQ_TAG = 16'hF_FFF // arbitrary, system chooses
) (
	input  wire              aclk,
	input  wire              aresetn,
	// register slave
	input  wire [11:0]       s_awaddr,
	input  wire              s_awvalid,
	output wire              s_awready,
	input  wire [31:0]       s_wdata,
	input  wire [3:0]        s_wstrb,
	input  wire              s_wvalid,
	output wire              s_wready,
	output reg  [1:0]        s_bresp,
	output reg               s_bvalid,
	input  wire              s_bready,
	input  wire [11:0]       s_araddr,
	input  wire              s_arvalid,
	output wire              s_arready,
	output reg  [31:0]       s_rdata,
	output reg  [1:0]        s_rresp,
	output reg               s_rvalid,
	input  wire              s_rready,
	// triggers from the rest of the unit, same clock
	input  wire              evtq_nonempty,
	input  wire              s_evtq_nonempty,
	input  wire              priq_irq_cond,
	input  wire              sync_done,
	input  wire              s_sync_done,
	input  wire              gerr_set,
	input  wire              info_visible,
	// client stream passthrough
	input  wire [SID_W-1:0]  client_stream_tag_in,
	output wire [SID_W-1:0]  client_stream_tag_out,
	// wired pulses
	output reg  [5:0]        irq_pulse,
	// message write, AXI4-Lite style master
	output reg  [63:0]       m_awaddr,
	output reg               m_awvalid,
	input  wire              m_awready,
	output reg  [31:0]       m_wdata,
	output reg               m_wvalid,
	input  wire              m_wready,
	output reg  [3:0]        m_memtype,
	output reg  [1:0]        m_share,
	output reg               m_nonsecure_attribute,
	output reg  [15:0]       m_requester_tag,
	input  wire              m_bvalid,
	output wire              m_bready
);
	localparam NS = `IMN_NSRC;
	localparam [NS-1:0] SEC = `IMN_SECURE_MASK;
	localparam ST_IDLE = 2'd0;
	localparam ST_SEND = 2'd1;
	localparam ST_RESP = 2'd2;

	reg [NS-1:0] en_q;
	reg [31:0]   addr_lo_q [0:NS-1];
	reg [31:0]   addr_hi_q [0:NS-1];
	reg [31:0]   data_q    [0:NS-1];
	reg [5:0]    attr_q    [0:NS-1];
	reg [NS-1:0] pend_q;
	reg [NS-1:0] hold_q;
	reg          evtq_q;
	reg          s_evtq_q;
	reg [1:0]    st_q;
	reg [1:0]    st_d;

	assign client_stream_tag_out = client_stream_tag_in;

	// empty to non-empty edges; others are already event pulses
	wire [NS-1:0] trig = {gerr_set, s_sync_done, sync_done, priq_irq_cond,
		s_evtq_nonempty & ~s_evtq_q, evtq_nonempty & ~evtq_q};

	// secure message support only with non-secure support
	localparam MSI_NS = (MSI_NS_SUPPORT != 0);
	localparam MSI_S  = (MSI_S_SUPPORT != 0) && MSI_NS;

	// register bus: write address and data taken together once both present
	reg          aw_q;
	reg          w_q;
	reg [11:0]   awa_q;
	reg [31:0]   wd_q;
	reg          ws_q;
	assign s_awready = ~aw_q & ~s_bvalid;
	assign s_wready  = ~w_q & ~s_bvalid;
	wire aw_now  = aw_q | s_awvalid;
	wire w_now   = w_q | s_wvalid;
	wire [11:0] wa = aw_q ? awa_q : s_awaddr;
	wire [31:0] wd = w_q ? wd_q : s_wdata;
	// strobe parked with its data, the address may come much later
	wire        ws = w_q ? ws_q : s_wstrb[0];
	wire do_wr = aw_now & w_now & ~s_bvalid;
	wire [2:0] wsrc = wa[7:5];
	wire [2:0] woff = wa[4:2];
	wire w_in_src = (wa >= `IMN_SRC_BASE) && (wsrc < NS) && (woff <= `IMN_OFF_ATTR)
		&& (wa[11:8] == `IMN_SRC_PAGE);
	wire w_ok = (wa == `IMN_REG_ENABLE) | w_in_src;

	assign s_arready = ~s_rvalid;
	wire [2:0] rsrc = s_araddr[7:5];
	wire [2:0] roff = s_araddr[4:2];
	wire r_in_src = (s_araddr[11:8] == `IMN_SRC_PAGE) && (rsrc < NS)
		&& (roff <= `IMN_OFF_ATTR);

	integer i;

	// a half that arrives alone is parked until its partner shows up
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			awa_q <= 12'h000;
		end else if (do_wr) begin
			aw_q <= 1'b0;
		end else if (s_awvalid & s_awready) begin
			aw_q <= 1'b1;
			awa_q <= s_awaddr;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			w_q <= 1'b0;
			wd_q <= 32'h0000_0000;
			ws_q <= 1'b0;
		end else if (do_wr) begin
			w_q <= 1'b0;
		end else if (s_wvalid & s_wready) begin
			w_q <= 1'b1;
			wd_q <= s_wdata;
			ws_q <= s_wstrb[0];
		end
	end

	// response stands until taken; both ready lines stay low meanwhile
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_bvalid <= 1'b0;
			s_bresp <= `IMN_RESP_OKAY;
		end else if (do_wr) begin
			s_bvalid <= 1'b1;
			s_bresp <= w_ok ? `IMN_RESP_OKAY : `IMN_RESP_SLVERR;
		end else if (s_bvalid & s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn)
			en_q <= {NS{1'b0}};
		else if (do_wr && wa == `IMN_REG_ENABLE && ws)
			en_q <= wd[NS-1:0];
	end

	// per-source configuration words
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < NS; i = i + 1) begin
				addr_lo_q[i] <= 32'h0000_0000;
				addr_hi_q[i] <= 32'h0000_0000;
				data_q[i] <= 32'h0000_0000;
				attr_q[i] <= 6'h00;
			end
		end else if (do_wr && w_in_src) begin
			case (woff)
			`IMN_OFF_ADDR_LO: addr_lo_q[wsrc] <= wd & `IMN_ADDR_LO_MASK;
			`IMN_OFF_ADDR_HI: addr_hi_q[wsrc] <= wd;
			`IMN_OFF_DATA:    data_q[wsrc] <= wd;
			default:          attr_q[wsrc] <= wd[5:0];
			endcase
		end
	end

	// read decode kept combinational; the word itself is registered below
	reg [31:0] rd_word;
	reg        rd_hit;
	always @* begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		if (s_araddr == `IMN_REG_IDR) begin
			rd_word = {28'h000_0000, COHACC != 0, WIRED_SUPPORT != 0, MSI_S, MSI_NS};
		end else if (s_araddr == `IMN_REG_ENABLE) begin
			rd_word = {{(32-NS){1'b0}}, en_q};
		end else if (s_araddr == `IMN_REG_STATUS) begin
			rd_word = {{(32-2*NS){1'b0}}, hold_q, pend_q};
		end else if (s_araddr == `IMN_REG_REQTAG) begin
			rd_word = {16'h0000, REQ_TAG};
		end else if (r_in_src) begin
			case (roff)
			`IMN_OFF_ADDR_LO: rd_word = addr_lo_q[rsrc];
			`IMN_OFF_ADDR_HI: rd_word = addr_hi_q[rsrc];
			`IMN_OFF_DATA:    rd_word = data_q[rsrc];
			default:          rd_word = {26'h000_0000, attr_q[rsrc]};
			endcase
		end else begin
			rd_hit = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rresp <= `IMN_RESP_OKAY;
			s_rdata <= 32'h0000_0000;
		end else if (s_arvalid & s_arready) begin
			s_rvalid <= 1'b1;
			s_rresp <= rd_hit ? `IMN_RESP_OKAY : `IMN_RESP_SLVERR;
			s_rdata <= rd_word;
		end else if (s_rvalid & s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// a trigger waits in hold until the visibility
	// strobe says index/error registers show the new state
	wire [NS-1:0] ready_now = (hold_q | trig) & {NS{info_visible}};
	wire [NS-1:0] msi_ok;
	wire [NS-1:0] fire = ready_now & en_q;
	wire [NS-1:0] pend_d;
	wire [NS-1:0] hold_d = (hold_q | trig) & ~{NS{info_visible}};

	// fixed lowest-index order keeps the arbiter tiny; a busy low
	// source that keeps refiring can hold off higher ones indefinitely
	reg [2:0] pick;
	reg       any;
	integer k;
	always @* begin
		pick = 3'd0;
		any = 1'b0;
		for (k = NS - 1; k >= 0; k = k - 1) begin
			if (pend_q[k]) begin
				pick = k[2:0];
				any = 1'b1;
			end
		end
	end

	wire [3:0] pmt = attr_q[pick][3:0];
	wire [1:0] psh = attr_q[pick][5:4];
	wire aw_done = ~m_awvalid | m_awready;
	wire w_done  = ~m_wvalid | m_wready;
	assign m_bready = (st_q == ST_RESP);
	wire launch = (st_q == ST_IDLE) & any;

	genvar g;
	generate
		for (g = 0; g < NS; g = g + 1) begin : g_src
			// address/data only matter with message support
			assign msi_ok[g] = (SEC[g] ? MSI_S : MSI_NS)
				&& ({addr_hi_q[g], addr_lo_q[g]} != 64'h0);
			// a repeat trigger folds into the bit already set
			// set wins over the clear of the source being launched
			assign pend_d[g] = (pend_q[g] & ~(launch && pick == g))
				| (fire[g] & msi_ok[g]);
		end
	endgenerate

	// remembered levels for the empty to non-empty edges
	always @(posedge aclk) begin
		if (!aresetn) begin
			evtq_q <= 1'b0;
			s_evtq_q <= 1'b0;
		end else begin
			evtq_q <= evtq_nonempty;
			s_evtq_q <= s_evtq_nonempty;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			hold_q <= {NS{1'b0}};
			pend_q <= {NS{1'b0}};
			irq_pulse <= 6'h00;
		end else begin
			hold_q <= hold_d;
			pend_q <= pend_d;
			irq_pulse <= (WIRED_SUPPORT != 0) ? fire : 6'h00;
		end
	end

	always @* begin
		st_d = st_q;
		case (st_q)
		ST_IDLE: if (any) st_d = ST_SEND;
		ST_SEND: if (aw_done & w_done) st_d = ST_RESP;
		ST_RESP: if (m_bvalid) st_d = ST_IDLE;
		default: st_d = ST_IDLE;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn)
			st_q <= ST_IDLE;
		else
			st_q <= st_d;
	end

	// each channel holds its valid until its own ready
	always @(posedge aclk) begin
		if (!aresetn) begin
			m_awvalid <= 1'b0;
			m_wvalid <= 1'b0;
		end else if (launch) begin
			m_awvalid <= 1'b1;
			m_wvalid <= 1'b1;
		end else begin
			if (m_awready)
				m_awvalid <= 1'b0;
			if (m_wready)
				m_wvalid <= 1'b0;
		end
	end

	// one 32-bit write; config snapshot taken at launch so a
	// software rewrite cannot tear a write already in flight
	always @(posedge aclk) begin
		if (!aresetn) begin
			m_awaddr <= 64'h0000_0000_0000_0000;
			m_wdata <= 32'h0000_0000;
			m_memtype <= 4'h0;
			m_share <= 2'h0;
			m_nonsecure_attribute <= 1'b0;
			m_requester_tag <= 16'h0000;
		end else if (launch) begin
			m_awaddr <= {addr_hi_q[pick], addr_lo_q[pick]};
			m_wdata <= data_q[pick];
			m_memtype <= pmt;
			// force outer shareable for device and non-cacheable
			m_share <= (pmt[3:2] == 2'b00 || pmt == `IMN_MT_NC) ? `IMN_SH_OUTER : psh;
			m_nonsecure_attribute <= ~SEC[pick];
			m_requester_tag <= REQ_TAG;
		end
	end
endmodule // imn_notifier
